// ===== rtl/rsb_pkg.sv
package rsb_pkg;

  localparam int RSB_NUM_M = 4;
  localparam int RSB_NUM_S = 4;
  localparam int RSB_DATA_W = 32;
  localparam int RSB_ADDR_W = 5;
  localparam int RSB_IDX_W = 2;

  typedef logic [RSB_DATA_W-1:0] rsb_data_t;
  typedef logic [RSB_ADDR_W-1:0] rsb_addr_t;
  typedef logic [RSB_IDX_W-1:0] rsb_idx_t;
  typedef logic [RSB_NUM_M-1:0] rsb_vec_t;

  typedef enum logic [0:0] {
    RSB_ARB_IDLE = 1'b0,
    RSB_ARB_OWNED = 1'b1
  } rsb_arb_state_t;

  localparam rsb_idx_t RSB_RESET_PTR = 2'h0;
  localparam rsb_idx_t RSB_IDX_STEP = 2'h1;
  localparam rsb_vec_t RSB_NONE = 4'h0;
  localparam rsb_vec_t RSB_ONE = 4'h1;
  localparam rsb_data_t RSB_DATA_ZERO = 32'h0000_0000;
  localparam rsb_addr_t RSB_ADDR_ZERO = 5'h00;

  // slave windows: eight words each
  localparam rsb_addr_t RSB_WIN_MASK = 5'h18;
  localparam rsb_addr_t RSB_WIN_BASE [RSB_NUM_S] = '{
    5'h00, 5'h08, 5'h10, 5'h18
  };

endpackage

// ===== rtl/rsb_arb_if.sv
`timescale 1ns/1ps
interface rsb_arb_if;
  import rsb_pkg::*;

  rsb_vec_t req;
  rsb_vec_t grant;
  rsb_idx_t owner;
  logic busy;

  modport arb (
    input req,
    output grant,
    output owner,
    output busy
  );

  modport fab (
    output req,
    input grant,
    input owner,
    input busy
  );
endinterface

// ===== rtl/rsb_arbiter.sv
`timescale 1ns/1ps
module rsb_arbiter (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // requests in, grant out
  rsb_arb_if.arb ab
);
  import rsb_pkg::*;

  rsb_arb_state_t state_q;
  rsb_idx_t owner_q;
  rsb_idx_t ptr_q;
  rsb_vec_t grant_q;
  rsb_idx_t start;
  rsb_idx_t pick;
  rsb_idx_t idx;
  logic found;
  logic keep;

  ////////////////////////////////////////////////////////////////////////////
  // rotating search

  always_comb begin
    keep = (state_q == RSB_ARB_OWNED) && ab.req[owner_q];
    // after a release the search begins one level past the old owner
    start = (state_q == RSB_ARB_OWNED) ? owner_q + RSB_IDX_STEP : ptr_q;
    found = 1'b0;
    pick = start;
    idx = start;
    for (int i = 0; i < RSB_NUM_M; i++) begin
      idx = start + rsb_idx_t'(i);
      if (!found && ab.req[idx]) begin
        found = 1'b1;
        pick = idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // grant register

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= RSB_ARB_IDLE;
      owner_q <= RSB_RESET_PTR;
      ptr_q <= RSB_RESET_PTR;
      grant_q <= RSB_NONE;
    end else if (keep) begin
      state_q <= RSB_ARB_OWNED;
    end else if (found) begin
      state_q <= RSB_ARB_OWNED;
      owner_q <= pick;
      ptr_q <= pick + RSB_IDX_STEP;
      grant_q <= RSB_ONE << pick;
    end else begin
      state_q <= RSB_ARB_IDLE;
      ptr_q <= start;
      grant_q <= RSB_NONE;
    end
  end

  assign ab.grant = grant_q;
  assign ab.owner = owner_q;
  assign ab.busy = (state_q == RSB_ARB_OWNED);

endmodule

// ===== rtl/rsb_fabric.sv
`timescale 1ns/1ps
module rsb_fabric (
  // clock and reset
  input logic SYS_CLK,
  input logic RESET_N,
  // master side
  input rsb_pkg::rsb_vec_t M_CYC,
  input rsb_pkg::rsb_vec_t M_STB,
  input rsb_pkg::rsb_vec_t M_WE,
  input rsb_pkg::rsb_addr_t M_ADR [rsb_pkg::RSB_NUM_M],
  input rsb_pkg::rsb_data_t M_DAT_WR [rsb_pkg::RSB_NUM_M],
  output rsb_pkg::rsb_vec_t M_ACK,
  output rsb_pkg::rsb_data_t M_DAT_RD [rsb_pkg::RSB_NUM_M],
  // arbitration
  output rsb_pkg::rsb_vec_t GRANT_LINE,
  // slave side
  output logic S_CYC,
  output logic S_WE,
  output rsb_pkg::rsb_addr_t S_ADR,
  output rsb_pkg::rsb_data_t S_DAT_WR,
  output rsb_pkg::rsb_vec_t S_STB,
  input rsb_pkg::rsb_vec_t S_ACK,
  input rsb_pkg::rsb_data_t S_DAT_RD [rsb_pkg::RSB_NUM_S]
);
  import rsb_pkg::*;

  rsb_arb_if arb_bus ();

  logic sel_cyc;
  logic sel_stb;
  logic sel_we;
  rsb_addr_t sel_adr;
  rsb_data_t sel_dat;
  rsb_vec_t hit;
  rsb_idx_t hit_idx;
  logic ack_any;
  rsb_data_t rd_sel;

  logic s_cyc_q;
  logic s_we_q;
  rsb_addr_t s_adr_q;
  rsb_data_t s_dat_q;
  rsb_vec_t s_stb_q;
  rsb_idx_t slave_q;
  rsb_vec_t m_ack_q;
  rsb_data_t m_rd_q [RSB_NUM_M];

  ////////////////////////////////////////////////////////////////////////////
  // arbiter

  assign arb_bus.req = M_CYC;

  rsb_arbiter u_arb (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .ab(arb_bus.arb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // master-to-shared multiplexers and address decode

  always_comb begin
    // an idle arbiter puts no cycle, strobe or write on the shared bus; address and data still follow the old owner
    sel_cyc = arb_bus.busy && M_CYC[arb_bus.owner];
    sel_stb = arb_bus.busy && M_STB[arb_bus.owner];
    sel_we = arb_bus.busy && M_WE[arb_bus.owner];
    sel_adr = M_ADR[arb_bus.owner];
    sel_dat = M_DAT_WR[arb_bus.owner];
  end

  always_comb begin
    hit = RSB_NONE;
    hit_idx = RSB_RESET_PTR;
    for (int i = 0; i < RSB_NUM_S; i++) begin
      if ((sel_adr & RSB_WIN_MASK) == RSB_WIN_BASE[i]) begin
        hit[i] = 1'b1;
        hit_idx = rsb_idx_t'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination and read data return

  // only acknowledge ends a cycle; error and retry do not exist here
  assign ack_any = (|S_ACK) && (|s_stb_q);
  assign rd_sel = S_DAT_RD[slave_q];

  ////////////////////////////////////////////////////////////////////////////
  // shared bus registers

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      s_cyc_q <= 1'b0;
      s_we_q <= 1'b0;
      s_adr_q <= RSB_ADDR_ZERO;
      s_dat_q <= RSB_DATA_ZERO;
      slave_q <= RSB_RESET_PTR;
    end else begin
      s_cyc_q <= sel_cyc;
      s_we_q <= sel_we;
      s_adr_q <= sel_adr;
      s_dat_q <= sel_dat;
      slave_q <= hit_idx;
    end
  end

  // strobe rests in the ack cycle and while the master ack is out: the
  // master still holds its strobe at the edge that samples that ack, and
  // that strobe must not start a second phase
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      s_stb_q <= RSB_NONE;
    end else if (sel_cyc && sel_stb && !ack_any && !(|m_ack_q)) begin
      s_stb_q <= hit;
    end else begin
      s_stb_q <= RSB_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master return registers

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      m_ack_q <= RSB_NONE;
    end else if (ack_any) begin
      m_ack_q <= arb_bus.grant;
    end else begin
      m_ack_q <= RSB_NONE;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      for (int i = 0; i < RSB_NUM_M; i++) begin
        m_rd_q[i] <= RSB_DATA_ZERO;
      end
    end else begin
      for (int i = 0; i < RSB_NUM_M; i++) begin
        if (ack_any && arb_bus.grant[i] && !s_we_q) begin
          m_rd_q[i] <= rd_sel;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign S_CYC = s_cyc_q;
  assign S_WE = s_we_q;
  assign S_ADR = s_adr_q;
  assign S_DAT_WR = s_dat_q;
  assign S_STB = s_stb_q;
  assign M_ACK = m_ack_q;
  assign M_DAT_RD = m_rd_q;
  assign GRANT_LINE = arb_bus.grant;

endmodule

// ===== verif/rsb_chk.sv
`timescale 1ns/1ps
module rsb_chk (
  // clock and reset
  input logic SYS_CLK,
  input logic RESET_N,
  // watched ports
  input logic S_CYC,
  input rsb_pkg::rsb_vec_t M_CYC,
  input rsb_pkg::rsb_vec_t M_ACK,
  input rsb_pkg::rsb_vec_t GRANT_LINE,
  input rsb_pkg::rsb_vec_t S_STB,
  input rsb_pkg::rsb_addr_t S_ADR,
  input rsb_pkg::rsb_vec_t S_ACK
);
  import rsb_pkg::*;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  a_grant_onehot: assert property ($onehot0(GRANT_LINE))
    else $error("grant not one-hot");
  a_grant_fast:
    assert property (|M_CYC && !GRANT_LINE |=> |GRANT_LINE)
    else $error("request left ungranted");
  a_grant_wanted:
    assert property (|GRANT_LINE |-> |(GRANT_LINE & $past(M_CYC)))
    else $error("grant to idle master");
  a_grant_hold:
    assert property (|(GRANT_LINE & M_CYC) |=> $stable(GRANT_LINE))
    else $error("grant moved under owner");
  a_ack_owner:
    assert property (|M_ACK |-> $onehot(M_ACK) && !(M_ACK & ~GRANT_LINE))
    else $error("ack to master without grant");
  a_ack_return:
    assert property (|(S_ACK & S_STB) |=> M_ACK == $past(GRANT_LINE))
    else $error("slave ack not returned");
  a_strobe_window:
    assert property (|S_STB |-> S_STB == 4'h1 << S_ADR[4:3])
    else $error("strobe outside window");
  a_strobe_gap: assert property (|M_ACK |-> !S_STB)
    else $error("strobe kept after ack");
  a_strobe_rest: assert property (|M_ACK |=> !S_STB)
    else $error("strobe restarted on an acked cycle");
  a_cycle_frame: assert property (|S_STB |-> S_CYC)
    else $error("strobe without shared cycle");
  a_reset_quiet:
    assert property (disable iff (1'b0) !RESET_N |=> !GRANT_LINE && !S_STB)
    else $error("busy after reset");
endmodule

bind rsb_fabric rsb_chk u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
  .S_CYC(S_CYC),
  .M_CYC(M_CYC), .M_ACK(M_ACK), .GRANT_LINE(GRANT_LINE), .S_STB(S_STB),
  .S_ADR(S_ADR), .S_ACK(S_ACK));

// ===== verif/rsb_mem_model.sv
`timescale 1ns/1ps
module rsb_mem_model (
  // clock and pacing
  input logic clk,
  input logic slow,
  // shared bus
  input logic we,
  input rsb_pkg::rsb_addr_t adr,
  input rsb_pkg::rsb_data_t dat_wr,
  input rsb_pkg::rsb_vec_t stb,
  output rsb_pkg::rsb_vec_t ack,
  output rsb_pkg::rsb_data_t dat_rd [rsb_pkg::RSB_NUM_S]
);
  import rsb_pkg::*;
  rsb_data_t mem_q [32];
  rsb_vec_t ack_q = 4'h0;
  rsb_vec_t wait_q = 4'h0;
  logic [3:0] tick_q = 4'h0;
  // one ack per strobe, one wait state when slow
  always_ff @(posedge clk) begin
    ack_q <= stb & ~ack_q & (wait_q | {4{~slow}});
    wait_q <= stb & ~wait_q & ~ack_q;
  end
  always_ff @(posedge clk) begin
    if (|(stb & ack_q) && we) begin
      mem_q[adr] <= dat_wr;
    end
  end
  always_ff @(posedge clk) tick_q <= tick_q + 4'h1;
  // outside an ack the read lines churn
  always_comb begin
    for (int i = 0; i < RSB_NUM_S; i++) begin
      dat_rd[i] = ack_q[i] ? mem_q[adr] : {8{tick_q}};
    end
  end
  assign ack = ack_q;
endmodule

// ===== verif/test_round_robin_shared_bus.sv
`timescale 1ns/1ps
module test_round_robin_shared_bus;
  import rsb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic s_cyc, s_we;
  rsb_vec_t cyc = 4'h0, stb = 4'h0, we = 4'h0, ack, grant, s_stb, s_ack;
  rsb_addr_t s_adr;
  rsb_addr_t adr [RSB_NUM_M] = '{default: 5'h00};
  rsb_data_t wd [RSB_NUM_M] = '{default: 32'h0};
  rsb_data_t rd [RSB_NUM_M];
  rsb_data_t s_rd [RSB_NUM_S];
  rsb_data_t s_wd;
  int fail_count = 0, compares = 0, cycles = 0;
  int order_q [$];

  rsb_fabric u_dut (.SYS_CLK(clk), .RESET_N(rst_n), .M_CYC(cyc),
    .M_STB(stb), .M_WE(we), .M_ADR(adr), .M_DAT_WR(wd), .M_ACK(ack),
    .M_DAT_RD(rd), .GRANT_LINE(grant), .S_CYC(s_cyc), .S_WE(s_we),
    .S_ADR(s_adr), .S_DAT_WR(s_wd), .S_STB(s_stb), .S_ACK(s_ack),
    .S_DAT_RD(s_rd));
  rsb_mem_model u_mem (.clk(clk), .slow(slow), .we(s_we), .adr(s_adr),
    .dat_wr(s_wd), .stb(s_stb), .ack(s_ack), .dat_rd(s_rd));

  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one single cycle by master m, held until its ack shows
  task automatic xfer(input int m, input logic w, input rsb_addr_t a,
      input rsb_data_t d);
    int n;
    n = 0;
    @(negedge clk);
    adr[m] = a;
    wd[m] = d;
    we[m] = w;
    cyc[m] = 1'b1;
    stb[m] = 1'b1;
    while (ack[m] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    order_q.push_back(m);
    if (!w) check(rd[m], d);
    @(negedge clk);
    cyc[m] = 1'b0;
    stb[m] = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // all four write at window edges from idle
  task test_rotation;
    fork
      xfer(0, 1'b1, 5'h00, 32'hC0DE_0000);
      xfer(1, 1'b1, 5'h0F, 32'hC0DE_0001);
      xfer(2, 1'b1, 5'h10, 32'hC0DE_0002);
      xfer(3, 1'b1, 5'h1F, 32'hC0DE_0003);
    join
    for (int k = 0; k < 4; k++) check(order_q[k], k);
    order_q.delete();
  endtask
  // two reads cross windows, idle levels skipped, slow slaves
  task test_skip;
    slow = 1'b1;
    fork
      xfer(3, 1'b0, 5'h00, 32'hC0DE_0000);
      xfer(1, 1'b0, 5'h1F, 32'hC0DE_0003);
    join
    check(order_q[0], 1);
    check(order_q[1], 3);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(grant, 4'h0);
    test_rotation();
    test_skip();
    final_report();
  end
endmodule
